/* File: pport_pkg.sv */
// package: shared constants and types for the parallel host byte port
package pport_pkg;
    localparam int DATA_W = 8;
    // ack pulse width on the link, in ns, and its cycle count at 100 MHz
    localparam int CLK_PERIOD_NS = 10;
    localparam int ACK_PULSE_NS = 500;
    localparam int ACK_CYCLES = (ACK_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // host init request low time, in ns
    localparam int INIT_PULSE_NS = 500;
    localparam int INIT_CYCLES = (INIT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
    typedef enum logic [2:0] {
        DEV_RESET, DEV_INIT, DEV_IDLE, DEV_HOLD, DEV_ACK
    } dev_state_t;
    typedef enum logic [2:0] {
        HST_IDLE, HST_SETUP, HST_STROBE, HST_WAIT_BUSY, HST_WAIT_ACK, HST_INIT
    } host_state_t;
endpackage

/* File: pport_if.sv */
// interface: parallel printer link between host and printer port
interface pport_if;
    logic [7:0] data;
    logic strobe_n;
    logic busy;
    logic ack_n;
    logic host_init_request_n;
    modport device (
        input data,
        input strobe_n,
        input host_init_request_n,
        output busy,
        output ack_n
    );
    modport host (
        output data,
        output strobe_n,
        output host_init_request_n,
        input busy,
        input ack_n
    );
endinterface

/* File: pport_device.sv */
// module: printer end of the parallel byte port
module pport_device (
    // clock, reset, enable
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic CE,
    // link to host
    pport_if.device LINK,
    // processor side
    input wire logic RD_N,
    output logic [pport_pkg::DATA_W-1:0] CPU_DATA,
    output logic BYTE_RECEIVED,
    input wire logic BUFFER_FULL,
    input wire logic INIT_DONE,
    input wire logic CHIP_RESET_FROM_CPU_N,
    output logic INIT_START,
    output logic ONLINE_LAMP
);
    import pport_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] stb_s_r, stb_s_nxt;
    logic [1:0] ini_s_r, ini_s_nxt;
    logic stb_d_r, stb_d_nxt;
    logic ini_d_r, ini_d_nxt;
    logic [DATA_W-1:0] dat_s1_r, dat_s2_r, dat_s1_nxt, dat_s2_nxt;

    always_comb begin
        stb_s_nxt = {stb_s_r[0], LINK.strobe_n};
        ini_s_nxt = {ini_s_r[0], LINK.host_init_request_n};
        dat_s1_nxt = LINK.data;
        dat_s2_nxt = dat_s1_r;
        stb_d_nxt = stb_s_r[1];
        ini_d_nxt = ini_s_r[1];
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            stb_s_r <= 2'h3;
            ini_s_r <= 2'h3;
            dat_s1_r <= DATA_RESET;
            dat_s2_r <= DATA_RESET;
            stb_d_r <= 1'b1;
            ini_d_r <= 1'b1;
        end else if (CE) begin
            // a low enable freezes the synchronisers too, so no edge is lost or doubled
            stb_s_r <= stb_s_nxt;
            ini_s_r <= ini_s_nxt;
            dat_s1_r <= dat_s1_nxt;
            dat_s2_r <= dat_s2_nxt;
            stb_d_r <= stb_d_nxt;
            ini_d_r <= ini_d_nxt;
        end
    end

    // data passes two stages like the strobe, so it is stable when the edge is seen
    logic strobe_fall;
    logic init_fall;
    assign strobe_fall = stb_d_r & ~stb_s_r[1];
    assign init_fall = ini_d_r & ~ini_s_r[1];

    // ------------------------------------------------------------
    // handshake state
    // ------------------------------------------------------------
    dev_state_t state_r, state_nxt;
    logic [DATA_W-1:0] hold_r, hold_nxt;
    logic busy_r, busy_nxt;
    logic ack_n_r, ack_n_nxt;
    logic rxd_r, rxd_nxt;
    logic lamp_r, lamp_nxt;
    logic init_r, init_nxt;
    // cnt_r times the ack pulse
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [DATA_W-1:0] cpu_r, cpu_nxt;
    logic rd_d_r, rd_d_nxt;
    logic read_done;

    // a read completes on the rising edge of the read strobe
    assign read_done = ~rd_d_r & RD_N;

    always_comb begin
        state_nxt = state_r;
        hold_nxt = hold_r;
        busy_nxt = busy_r;
        ack_n_nxt = ack_n_r;
        rxd_nxt = rxd_r;
        lamp_nxt = lamp_r;
        init_nxt = 1'b0;
        cnt_nxt = cnt_r;
        cpu_nxt = cpu_r;
        rd_d_nxt = RD_N;
        // the byte is registered onto the bus, so it stays there until the next read
        if (!RD_N) begin
            cpu_nxt = hold_r;
        end
        if (init_fall || !CHIP_RESET_FROM_CPU_N) begin
            // processor keeps running; only this port restarts
            state_nxt = DEV_INIT;
            busy_nxt = 1'b1;
            ack_n_nxt = 1'b1;
            rxd_nxt = 1'b0;
            lamp_nxt = 1'b0;
            init_nxt = init_fall;
        end else begin
            case (state_r)
                DEV_RESET: begin
                    // power-on: start the init program once, as after a host request
                    state_nxt = DEV_INIT;
                    init_nxt = 1'b1;
                end
                DEV_INIT: begin
                    // busy stays high until the program reports that it is done
                    if (INIT_DONE) begin
                        busy_nxt = 1'b0;
                        ack_n_nxt = 1'b0;
                        lamp_nxt = 1'b1;
                        cnt_nxt = CNT_W'(ACK_CYCLES - 1);
                        state_nxt = DEV_ACK;
                    end
                end
                DEV_IDLE: begin
                    if (strobe_fall) begin
                        hold_nxt = dat_s2_r;
                        busy_nxt = 1'b1;
                        rxd_nxt = 1'b1;
                        state_nxt = DEV_HOLD;
                    end
                end
                DEV_HOLD: begin
                    // strobes are ignored here and the hold register is frozen
                    if (read_done) begin
                        rxd_nxt = 1'b0;
                    end
                    // a full buffer keeps busy high and holds the ack back
                    if (!rxd_r && !BUFFER_FULL) begin
                        busy_nxt = 1'b0;
                        state_nxt = DEV_ACK;
                        cnt_nxt = CNT_W'(ACK_CYCLES - 1);
                    end
                end
                DEV_ACK: begin
                    ack_n_nxt = 1'b0;
                    // counting starts once ack is low, so the pulse is a full ACK_CYCLES long
                    if (!ack_n_r) begin
                        if (cnt_r == '0) begin
                            ack_n_nxt = 1'b1;
                            state_nxt = DEV_IDLE;
                        end else begin
                            cnt_nxt = cnt_r - CNT_W'(1);
                        end
                    end
                end
                default: state_nxt = DEV_RESET;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            state_r <= DEV_RESET;
            hold_r <= DATA_RESET;
            busy_r <= 1'b1;
            ack_n_r <= 1'b1;
            rxd_r <= 1'b0;
            lamp_r <= 1'b0;
            init_r <= 1'b0;
            cnt_r <= '0;
            cpu_r <= DATA_RESET;
            rd_d_r <= 1'b1;
        end else if (CE) begin
            state_r <= state_nxt;
            hold_r <= hold_nxt;
            busy_r <= busy_nxt;
            ack_n_r <= ack_n_nxt;
            rxd_r <= rxd_nxt;
            lamp_r <= lamp_nxt;
            init_r <= init_nxt;
            cnt_r <= cnt_nxt;
            cpu_r <= cpu_nxt;
            rd_d_r <= rd_d_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs, all straight from registers
    // ------------------------------------------------------------
    assign LINK.busy = busy_r;
    assign LINK.ack_n = ack_n_r;
    assign CPU_DATA = cpu_r;
    assign BYTE_RECEIVED = rxd_r;
    assign INIT_START = init_r;
    assign ONLINE_LAMP = lamp_r;
endmodule

/* File: pport_host.sv */
// module: host end of the parallel printer link
module pport_host (
    // clock, reset, enable
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic CE,
    // link to printer
    pport_if.host LINK,
    // user side
    input wire logic [pport_pkg::DATA_W-1:0] TX_DATA,
    input wire logic TX_VALID,
    output logic TX_READY,
    input wire logic INIT_REQ
);
    import pport_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] busy_s_r, busy_s_nxt;
    logic [1:0] ack_s_r, ack_s_nxt;
    logic ack_d_r, ack_d_nxt;

    always_comb begin
        busy_s_nxt = {busy_s_r[0], LINK.busy};
        ack_s_nxt = {ack_s_r[0], LINK.ack_n};
        ack_d_nxt = ack_s_r[1];
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            busy_s_r <= 2'h3;
            ack_s_r <= 2'h3;
            ack_d_r <= 1'b1;
        end else if (CE) begin
            busy_s_r <= busy_s_nxt;
            ack_s_r <= ack_s_nxt;
            ack_d_r <= ack_d_nxt;
        end
    end

    logic ack_fall;
    logic busy_seen;
    assign ack_fall = ack_d_r & ~ack_s_r[1];
    assign busy_seen = busy_s_r[1];

    // ------------------------------------------------------------
    // send sequencer
    // ------------------------------------------------------------
    host_state_t state_r, state_nxt;
    logic [DATA_W-1:0] data_r, data_nxt;
    logic strobe_n_r, strobe_n_nxt;
    logic init_n_r, init_n_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic ack_seen_r, ack_seen_nxt;

    always_comb begin
        state_nxt = state_r;
        data_nxt = data_r;
        strobe_n_nxt = strobe_n_r;
        init_n_nxt = init_n_r;
        cnt_nxt = cnt_r;
        ack_seen_nxt = ack_seen_r;
        case (state_r)
            HST_IDLE: begin
                if (INIT_REQ) begin
                    init_n_nxt = 1'b0;
                    cnt_nxt = CNT_W'(INIT_CYCLES - 1);
                    state_nxt = HST_INIT;
                end else if (TX_VALID && !busy_seen) begin
                    data_nxt = TX_DATA;
                    ack_seen_nxt = 1'b0;
                    cnt_nxt = CNT_W'(ACK_CYCLES - 1);
                    state_nxt = HST_SETUP;
                end
            end
            HST_SETUP: begin
                if (cnt_r == '0) begin
                    strobe_n_nxt = 1'b0;
                    cnt_nxt = CNT_W'(ACK_CYCLES - 1);
                    state_nxt = HST_STROBE;
                end else begin
                    cnt_nxt = cnt_r - CNT_W'(1);
                end
            end
            HST_STROBE: begin
                // a quick printer may ack before the strobe ends; keep it for later
                if (ack_fall) begin
                    ack_seen_nxt = 1'b1;
                end
                if (cnt_r == '0) begin
                    strobe_n_nxt = 1'b1;
                    state_nxt = HST_WAIT_BUSY;
                end else begin
                    cnt_nxt = cnt_r - CNT_W'(1);
                end
            end
            HST_WAIT_BUSY: begin
                if (ack_seen_r || ack_fall) begin
                    state_nxt = HST_IDLE;
                end else if (busy_seen) begin
                    state_nxt = HST_WAIT_ACK;
                end
            end
            HST_WAIT_ACK: begin
                if (ack_fall) begin
                    state_nxt = HST_IDLE;
                end
            end
            HST_INIT: begin
                if (cnt_r == '0) begin
                    init_n_nxt = 1'b1;
                    state_nxt = HST_IDLE;
                end else begin
                    cnt_nxt = cnt_r - CNT_W'(1);
                end
            end
            default: state_nxt = HST_IDLE;
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            state_r <= HST_IDLE;
            data_r <= DATA_RESET;
            strobe_n_r <= 1'b1;
            init_n_r <= 1'b1;
            cnt_r <= '0;
            ack_seen_r <= 1'b0;
        end else if (CE) begin
            state_r <= state_nxt;
            data_r <= data_nxt;
            strobe_n_r <= strobe_n_nxt;
            init_n_r <= init_n_nxt;
            cnt_r <= cnt_nxt;
            ack_seen_r <= ack_seen_nxt;
        end
    end

    assign TX_READY = (state_r == HST_IDLE) & ~busy_seen & ~INIT_REQ;
    assign LINK.data = data_r;
    assign LINK.strobe_n = strobe_n_r;
    assign LINK.host_init_request_n = init_n_r;
endmodule

/* File: pport_link_props.sv */
// checker: timing properties of the host to printer link
module pport_link_props
    import pport_pkg::*;
(
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // link signals
    input wire logic [7:0] data,
    input wire logic strobe_n,
    input wire logic busy,
    input wire logic ack_n,
    input wire logic host_init_request_n
);
    logic [CNT_W-1:0] ack_cnt_r, ack_cnt_nxt, stb_cnt_r, stb_cnt_nxt;
    // ----
    // low-time counters, read at the rising edge that ends a pulse
    // ----
    always_comb begin
        ack_cnt_nxt = ack_n ? '0 : ack_cnt_r + 1'b1;
        stb_cnt_nxt = strobe_n ? '0 : stb_cnt_r + 1'b1;
    end
    always_ff @(posedge CLK_SYS) begin
        ack_cnt_r <= RST ? '0 : ack_cnt_nxt;
        stb_cnt_r <= RST ? '0 : stb_cnt_nxt;
    end
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    strobe_busy_a: assert property ($fell(strobe_n) |-> ##[1:5] busy)
        else $error("busy not raised after strobe");
    ack_idle_a: assert property (!ack_n |-> !busy)
        else $error("ack low while busy");
    ack_width_a: assert property ($rose(ack_n) |-> ack_cnt_r == ACK_CYCLES)
        else $error("ack pulse width wrong");
    strobe_width_a: assert property ($rose(strobe_n) |-> stb_cnt_r == ACK_CYCLES)
        else $error("strobe pulse width wrong");
    strobe_free_a: assert property ($fell(strobe_n) |-> !busy && ack_n)
        else $error("strobe sent while busy or acking");
    data_hold_a: assert property (!strobe_n |-> $stable(data))
        else $error("data moved during strobe");
    busy_ack_a: assert property ($fell(busy) |-> ##[1:2] !ack_n)
        else $error("no ack after busy release");
    init_busy_a: assert property ($fell(host_init_request_n) |-> ##[1:5] busy)
        else $error("busy not raised on init request");
endmodule

/* File: test_parallel_host_byte_receiver.sv */
// testbench: host end and printer end joined over the link
module test_parallel_host_byte_receiver;
    timeunit 1ns;
    timeprecision 100ps;
    import pport_pkg::*;
    typedef struct {logic [7:0] d; logic full;} row_t;
    logic CLK_SYS, RST, CE, RD_N, BUFFER_FULL, INIT_DONE, CHIP_RESET_FROM_CPU_N;
    logic TX_VALID, INIT_REQ, BYTE_RECEIVED, INIT_START, ONLINE_LAMP, TX_READY;
    logic [DATA_W-1:0] TX_DATA, CPU_DATA;
    int fails = 0;
    int n_checks = 0;
    int cycles = 0;
    int i, k;
    // full flag holds the buffer full for a while after the read
    row_t rows[4] = '{'{8'h3c, 1'b0}, '{8'hff, 1'b0}, '{8'ha5, 1'b1}, '{8'h5a, 1'b0}};
    pport_if pport_if_inst();
    pport_device pport_device_inst(.CLK_SYS(CLK_SYS), .RST(RST), .CE(CE),
        .LINK(pport_if_inst), .RD_N(RD_N), .CPU_DATA(CPU_DATA),
        .BYTE_RECEIVED(BYTE_RECEIVED), .BUFFER_FULL(BUFFER_FULL), .INIT_DONE(INIT_DONE),
        .CHIP_RESET_FROM_CPU_N(CHIP_RESET_FROM_CPU_N), .INIT_START(INIT_START),
        .ONLINE_LAMP(ONLINE_LAMP));
    pport_host pport_host_inst(.CLK_SYS(CLK_SYS), .RST(RST), .CE(CE),
        .LINK(pport_if_inst), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID),
        .TX_READY(TX_READY), .INIT_REQ(INIT_REQ));
    pport_link_props pport_link_props_inst(.CLK_SYS(CLK_SYS), .RST(RST),
        .data(pport_if_inst.data), .strobe_n(pport_if_inst.strobe_n),
        .busy(pport_if_inst.busy), .ack_n(pport_if_inst.ack_n),
        .host_init_request_n(pport_if_inst.host_init_request_n));
    // ----
    // shared tasks
    // ----
    task automatic tick(int n = 1);
        repeat (n) @(posedge CLK_SYS);
        #1;
    endtask
    task automatic check(string name, logic [7:0] exp, logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic wait_ack();
        for (k = 0; k < 400 && pport_if_inst.ack_n !== 1'b0; k++) tick();
        check("ack_n low", 8'h00, pport_if_inst.ack_n);
        for (k = 0; k < 100 && pport_if_inst.ack_n !== 1'b1; k++) tick();
    endtask
    // window covers the longest init pulse the host sends
    task automatic finish_init(logic [7:0] start_exp);
        logic seen;
        seen = 1'b0;
        for (k = 0; k < 60; k++) begin
            tick();
            seen = seen | INIT_START;
        end
        check("init start", start_exp, seen);
        check("busy in init", 8'h01, pport_if_inst.busy);
        check("lamp in init", 8'h00, ONLINE_LAMP);
        INIT_DONE = 1'b1;
        tick();
        INIT_DONE = 1'b0;
        wait_ack();
        check("lamp on", 8'h01, ONLINE_LAMP);
    endtask
    task automatic send_byte(row_t r);
        for (k = 0; k < 100 && TX_READY !== 1'b1; k++) tick();
        TX_DATA = r.d;
        TX_VALID = 1'b1;
        tick();
        TX_VALID = 1'b0;
        for (k = 0; k < 200 && BYTE_RECEIVED !== 1'b1; k++) tick();
        check("busy", 8'h01, pport_if_inst.busy);
        check("byte received", 8'h01, BYTE_RECEIVED);
        check("tx ready", 8'h00, TX_READY);
        tick(20);
        check("busy held", 8'h01, pport_if_inst.busy);
        RD_N = 1'b0;
        tick(2);
        check("cpu data", r.d, CPU_DATA);
        BUFFER_FULL = r.full;
        RD_N = 1'b1;
        if (r.full) begin
            tick(60);
            check("busy full", 8'h01, pport_if_inst.busy);
            check("ack full", 8'h01, pport_if_inst.ack_n);
            BUFFER_FULL = 1'b0;
        end
        wait_ack();
        check("byte cleared", 8'h00, BYTE_RECEIVED);
    endtask
    // ----
    // clock, watchdog and main sequence
    // ----
    initial begin
        CLK_SYS = 1'b0;
        forever #5 CLK_SYS = ~CLK_SYS;
    end
    always @(posedge CLK_SYS) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            report_and_stop();
        end
    end
    initial begin
        {RST, CE, RD_N, CHIP_RESET_FROM_CPU_N} = 4'hf;
        {BUFFER_FULL, INIT_DONE, TX_VALID, INIT_REQ} = 4'h0;
        TX_DATA = 8'h00;
        tick(5);
        check("busy in reset", 8'h01, pport_if_inst.busy);
        check("ack in reset", 8'h01, pport_if_inst.ack_n);
        check("lamp in reset", 8'h00, ONLINE_LAMP);
        RST = 1'b0;
        finish_init(8'h01);
        for (i = 0; i < 4; i++) send_byte(rows[i]);
        INIT_REQ = 1'b1;
        tick();
        INIT_REQ = 1'b0;
        finish_init(8'h01);
        send_byte(rows[1]);
        CHIP_RESET_FROM_CPU_N = 1'b0;
        tick(3);
        CHIP_RESET_FROM_CPU_N = 1'b1;
        finish_init(8'h00);
        send_byte(rows[2]);
        report_and_stop();
    end
endmodule
